// ===== shared/sfp_pkg.sv
// Purpose: Shared constants and carriers for the slave FIFO host port
// Assumes: Wishbone registers sit one per aligned 32-bit word
// Notes: Config words cross to the link clock as quasi-static levels

package sfp_pkg;

    // ========================================
    // Register byte addresses
    localparam logic [7:0] ADR_IFCFG = 8'h00;
    localparam logic [7:0] ADR_POLARITY_CONFIG_REG = 8'h04;
    localparam logic [7:0] ADR_FLAGCFG = 8'h08;
    localparam logic [7:0] ADR_FSTAT = 8'h0c;
    localparam logic [7:0] ADR_TXDATA = 8'h10;
    localparam logic [7:0] ADR_RXDATA = 8'h14;
    localparam logic [7:0] ADR_STATUS = 8'h18;

    // ========================================
    // Field positions
    localparam int IFC_INT_SRC = 7;
    localparam int IFC_PIN_OE = 6;
    localparam int IFC_RATE48 = 5;
    localparam int IFC_INVERT = 4;
    localparam int IFC_WIDE = 0;
    localparam int POL_RD = 3;
    localparam int POL_WR = 2;
    localparam int FA_LSB = 0;
    localparam int FB_LSB = 2;
    localparam int FC_LSB = 4;
    localparam int FS_PF_LSB = 0;
    localparam int FS_FULL_LSB = 4;
    localparam int FS_EMPTY_LSB = 8;

    // ========================================
    // Reset values and codes
    localparam logic [7:0] IFCFG_RST = 8'h01;
    localparam logic [7:0] POLARITY_CONFIG_REG_RST = 8'h00;
    localparam logic [5:0] FLAGCFG_RST = 6'h24;
    localparam logic [11:0] FSTAT_RST = 12'hf00;
    localparam logic [2:0] CMD_SEL = 3'h4;

    // ========================================
    // Types
    typedef enum logic [1:0] {
        FSRC_PF = 2'h0,
        FSRC_FULL = 2'h1,
        FSRC_EMPTY = 2'h2,
        FSRC_OFF = 2'h3
    } sfp_fsrc_t;

    typedef enum logic [1:0] {
        WB_IDLE = 2'h1,
        WB_ACK = 2'h2
    } sfp_wb_st_t;

    // Levels passed from the system clock to the link clock
    typedef struct packed {
        logic rst;
        logic ce;
        logic [7:0] ifcfg;
        logic [7:0] polarity_config_reg;
        logic [5:0] flagcfg;
        logic [11:0] fstat;
        logic tx_tgl;
        logic rx_ack;
    } sfp_xfer_t;

    // Toggles passed back from the link clock
    typedef struct packed {
        logic rx_tgl;
        logic tx_ack;
    } sfp_back_t;

endpackage : sfp_pkg

// ===== hw/sfp_sync.sv
// Purpose: Two-flop synchroniser for a bundle of levels
// Assumes: Multi-bit inputs are held stable for many destination cycles
// Notes: Not reset, so it can carry the reset itself

`timescale 1ns/1ps

module sfp_sync #(
    parameter int W = 1
) (
    // Destination clock
    input wire logic clk_i,
    // Level in and synchronised level out
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sfp_sync_st_t;

    sfp_sync_st_t st_reg;
    sfp_sync_st_t st_next;

    // ========================================
    // First flop feeds only the second
    always_comb begin
        st_next.s1 = d_i;
        st_next.s2 = st_reg.s1;
    end

    always_ff @(posedge clk_i) begin
        st_reg <= st_next;
    end

    assign q_o = st_reg.s2;

endmodule : sfp_sync

// ===== hw/sfp_port.sv
// Purpose: Slave FIFO host port pins with a Wishbone register side
// Assumes: Strobes, select and data pins are synchronous to link_clk_i
// Notes: One word each way is held; full and empty flags pace the master
//
// How it works
// RQ1 - Low byte carries FIFO data and commands
// RQ2 - High byte carries FIFO data, never commands
// RQ3 - Read strobe level set by polarity bit three
// RQ4 - Write strobe level set by polarity bit two
// RQ5 - First flag defaults to selected level flag
// RQ6 - Second flag defaults to selected FIFO full
// RQ7 - Third flag defaults to selected FIFO empty
// RQ8 - Pins transfer and time on interface clock
// RQ9 - Internal source drives clock pin, 30/48 MHz
// RQ10 - Config bit four inverts the interface clock
// RQ11 - Master drives select lines choosing the FIFO
// RQ12 - Eight-bit mode leaves high byte undriven
//
// The Wishbone slave port and the register offsets were chosen for this implementation.

`timescale 1ns/1ps

module sfp_port (
    // System clock and control
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Link side, all on the interface clock
    input wire logic link_clk_i,
    input wire logic [2:0] fifo_select_lines_i,
    input wire logic fifo_read_strobe_i,
    input wire logic fifo_write_strobe_i,
    input wire logic [15:0] fifo_data_lines_i,
    output logic [15:0] fifo_data_lines_o,
    output logic [1:0] fifo_data_lines_oe_o,
    output logic status_flag_first_o,
    output logic status_flag_second_o,
    output logic status_flag_third_o,
    // Interface clock pin and internal source control
    output logic interface_clock_o,
    output logic interface_clock_oe_o,
    output logic ifc_rate48_o
);

    typedef struct packed {
        sfp_pkg::sfp_wb_st_t wb_st;
        logic [31:0] rdat;
        logic [7:0] ifcfg;
        logic [7:0] polarity_config_reg;
        logic [5:0] flagcfg;
        logic [11:0] fstat;
        logic [15:0] tx_data;
        logic tx_tgl;
        logic [15:0] rx_data;
        logic rx_cmd;
        logic [2:0] rx_sel;
        logic rx_valid;
        logic rx_ack;
    } sfp_sys_t;

    typedef struct packed {
        logic [15:0] dout;
        logic [1:0] doe;
        logic [2:0] flags;
        logic [15:0] tx_hold;
        logic tx_have;
        logic tx_ack;
        logic [15:0] rx_hold;
        logic rx_cmd;
        logic [2:0] rx_sel;
        logic rx_tgl;
        logic inv;
    } sfp_lnk_t;

    sfp_sys_t s_reg;
    sfp_sys_t s_next;
    sfp_lnk_t l_reg;
    sfp_lnk_t l_next;
    sfp_pkg::sfp_xfer_t xfer_d;
    sfp_pkg::sfp_xfer_t x;
    sfp_pkg::sfp_back_t back_d;
    sfp_pkg::sfp_back_t b;
    logic lrst;
    logic lce;
    logic rd_on;
    logic wr_on;
    logic cmd;
    logic port_ok;
    logic wide;
    logic busy;
    logic pf_sel;
    logic full_sel;
    logic empty_sel;
    logic acc;
    logic tx_pend;

    // ========================================
    // Helpers

    // Strobe is active when the pin equals the programmed level
    function automatic logic strobe_on(input logic pin, input logic act_high);
        strobe_on = (pin == act_high);
    endfunction : strobe_on

    // Per-FIFO bit for the selected FIFO; command and spare codes give zero
    function automatic logic sel_bit(input logic [3:0] v, input logic [2:0] sel);
        sel_bit = sel[2] ? 1'b0 : v[sel[1:0]];
    endfunction : sel_bit

    // Flag source multiplexer shared by all three flag pins
    function automatic logic flag_pick(input logic [1:0] src, input logic pf,
                                       input logic full, input logic empty);
        case (src)
            sfp_pkg::FSRC_PF: flag_pick = pf;
            sfp_pkg::FSRC_FULL: flag_pick = full;
            sfp_pkg::FSRC_EMPTY: flag_pick = empty;
            default: flag_pick = 1'b0;
        endcase
    endfunction : flag_pick

    // Byte-lane merge for 16-bit registers
    function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] sel);
        wr16[7:0] = sel[0] ? d[7:0] : old[7:0];
        wr16[15:8] = sel[1] ? d[15:8] : old[15:8];
    endfunction : wr16

    // ========================================
    // Clock-domain crossings

    // Config is quasi-static, so plain level synchronisers suffice
    always_comb begin
        xfer_d.rst = rst_i;
        xfer_d.ce = ce_i;
        xfer_d.ifcfg = s_reg.ifcfg;
        xfer_d.polarity_config_reg = s_reg.polarity_config_reg;
        xfer_d.flagcfg = s_reg.flagcfg;
        xfer_d.fstat = s_reg.fstat;
        xfer_d.tx_tgl = s_reg.tx_tgl;
        xfer_d.rx_ack = s_reg.rx_ack;
        back_d.rx_tgl = l_reg.rx_tgl;
        back_d.tx_ack = l_reg.tx_ack;
    end

    sfp_sync #(.W($bits(sfp_pkg::sfp_xfer_t))) u_to_link (
        .clk_i(link_clk_i),
        .d_i(xfer_d),
        .q_o(x)
    );

    sfp_sync #(.W($bits(sfp_pkg::sfp_back_t))) u_to_sys (
        .clk_i(clk_i),
        .d_i(back_d),
        .q_o(b)
    );

    // ========================================
    // Link domain: pins sampled and driven on the interface clock

    // Decode of the pins for this cycle
    always_comb begin
        lrst = x.rst;
        lce = x.ce;
        rd_on = strobe_on(fifo_read_strobe_i, x.polarity_config_reg[sfp_pkg::POL_RD]); // [RQ3]
        wr_on = strobe_on(fifo_write_strobe_i, x.polarity_config_reg[sfp_pkg::POL_WR]); // [RQ4]
        cmd = (fifo_select_lines_i == sfp_pkg::CMD_SEL); // [RQ11]
        port_ok = !fifo_select_lines_i[2] || cmd;
        // Commands and narrow mode use the low byte alone
        wide = x.ifcfg[sfp_pkg::IFC_WIDE] && !cmd; // [RQ2] [RQ12]
        busy = (l_reg.rx_tgl != x.rx_ack);
        pf_sel = sel_bit(x.fstat[sfp_pkg::FS_PF_LSB +: 4], fifo_select_lines_i);
        // Unread word or software full both raise full; only the unread word blocks further writes
        full_sel = sel_bit(x.fstat[sfp_pkg::FS_FULL_LSB +: 4], fifo_select_lines_i) || busy;
        empty_sel = sel_bit(x.fstat[sfp_pkg::FS_EMPTY_LSB +: 4], fifo_select_lines_i)
                    || !l_reg.tx_have;
    end

    // Link state update
    always_comb begin
        l_next = l_reg;
        l_next.doe = 2'h0;
        // Pick up a word software queued; it stays stable until acknowledged
        if (x.tx_tgl != l_reg.tx_ack && !l_reg.tx_have) begin
            l_next.tx_hold = s_reg.tx_data;
            l_next.tx_have = 1'b1;
            l_next.tx_ack = ~l_reg.tx_ack;
        end
        // One word leaves per active read cycle
        if (rd_on && port_ok && l_reg.tx_have) begin // [RQ3] [RQ8]
            l_next.dout = {wide ? l_reg.tx_hold[15:8] : 8'h00, l_reg.tx_hold[7:0]}; // [RQ1]
            l_next.doe = {wide, 1'b1}; // [RQ2] [RQ12]
            l_next.tx_have = 1'b0;
        end
        // One word enters per active write cycle unless the hold is busy
        if (wr_on && port_ok && !busy) begin // [RQ4] [RQ8]
            l_next.rx_hold = {wide ? fifo_data_lines_i[15:8] : 8'h00,
                              fifo_data_lines_i[7:0]}; // [RQ1] [RQ2]
            l_next.rx_cmd = cmd;
            l_next.rx_sel = fifo_select_lines_i;
            l_next.rx_tgl = ~l_reg.rx_tgl;
        end
        l_next.flags[0] = flag_pick(x.flagcfg[sfp_pkg::FA_LSB +: 2],
                                    pf_sel, full_sel, empty_sel); // [RQ5]
        l_next.flags[1] = flag_pick(x.flagcfg[sfp_pkg::FB_LSB +: 2],
                                    pf_sel, full_sel, empty_sel); // [RQ6]
        l_next.flags[2] = flag_pick(x.flagcfg[sfp_pkg::FC_LSB +: 2],
                                    pf_sel, full_sel, empty_sel); // [RQ7]
        l_next.inv = x.ifcfg[sfp_pkg::IFC_INVERT]; // [RQ10]
        if (lrst) begin
            l_next = '0;
        end else if (!lce) begin
            l_next = l_reg;
        end
    end

    always_ff @(posedge link_clk_i) begin
        l_reg <= l_next;
    end

    // ========================================
    // System domain: Wishbone slave and registers

    always_comb begin
        acc = wb_cyc_i && wb_stb_i;
        tx_pend = (s_reg.tx_tgl != b.tx_ack);
    end

    // Register file; writes land on the edge where ack is seen
    always_comb begin
        s_next = s_reg;
        case (s_reg.wb_st)
            sfp_pkg::WB_IDLE: begin
                if (acc) begin
                    s_next.wb_st = sfp_pkg::WB_ACK;
                    case (wb_adr_i)
                        sfp_pkg::ADR_IFCFG: s_next.rdat = {24'h000000, s_reg.ifcfg};
                        sfp_pkg::ADR_POLARITY_CONFIG_REG: s_next.rdat = {24'h000000, s_reg.polarity_config_reg};
                        sfp_pkg::ADR_FLAGCFG: s_next.rdat = {26'h0000000, s_reg.flagcfg};
                        sfp_pkg::ADR_FSTAT: s_next.rdat = {20'h00000, s_reg.fstat};
                        sfp_pkg::ADR_TXDATA: s_next.rdat = {16'h0000, s_reg.tx_data};
                        sfp_pkg::ADR_RXDATA: s_next.rdat = {16'h0000, s_reg.rx_data};
                        sfp_pkg::ADR_STATUS: s_next.rdat = {26'h0000000, s_reg.rx_sel,
                                                   s_reg.rx_cmd, tx_pend, s_reg.rx_valid};
                        default: s_next.rdat = 32'h00000000;
                    endcase
                end
            end
            sfp_pkg::WB_ACK: begin
                s_next.wb_st = sfp_pkg::WB_IDLE;
                if (acc && wb_we_i) begin
                    case (wb_adr_i)
                        sfp_pkg::ADR_IFCFG: begin
                            if (wb_sel_i[0]) s_next.ifcfg = wb_dat_i[7:0]; // [RQ9] [RQ10]
                        end
                        sfp_pkg::ADR_POLARITY_CONFIG_REG: begin
                            if (wb_sel_i[0]) s_next.polarity_config_reg = wb_dat_i[7:0];
                        end
                        sfp_pkg::ADR_FLAGCFG: begin
                            if (wb_sel_i[0]) s_next.flagcfg = wb_dat_i[5:0];
                        end
                        sfp_pkg::ADR_FSTAT: begin
                            s_next.fstat = 12'(wr16({4'h0, s_reg.fstat}, wb_dat_i, wb_sel_i));
                        end
                        sfp_pkg::ADR_TXDATA: begin
                            // Refused while the previous word is still in flight
                            if (!tx_pend) begin
                                s_next.tx_data = wr16(s_reg.tx_data, wb_dat_i, wb_sel_i);
                                s_next.tx_tgl = ~s_reg.tx_tgl;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
                if (acc && !wb_we_i && wb_adr_i == sfp_pkg::ADR_RXDATA) begin
                    s_next.rx_valid = 1'b0;
                end
            end
            default: s_next.wb_st = sfp_pkg::WB_IDLE;
        endcase
        // Capture after the clear so an arriving word is never lost
        if (b.rx_tgl != s_reg.rx_ack && !s_reg.rx_valid) begin
            s_next.rx_data = l_reg.rx_hold;
            s_next.rx_cmd = l_reg.rx_cmd;
            s_next.rx_sel = l_reg.rx_sel;
            s_next.rx_valid = 1'b1;
            s_next.rx_ack = ~s_reg.rx_ack;
        end
        if (rst_i) begin
            s_next = '0;
            s_next.wb_st = sfp_pkg::WB_IDLE;
            s_next.ifcfg = sfp_pkg::IFCFG_RST;
            s_next.polarity_config_reg = sfp_pkg::POLARITY_CONFIG_REG_RST;
            s_next.flagcfg = sfp_pkg::FLAGCFG_RST;
            s_next.fstat = sfp_pkg::FSTAT_RST;
        end else if (!ce_i) begin
            s_next = s_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        s_reg <= s_next;
    end

    // ========================================
    // Outputs

    assign wb_ack_o = (s_reg.wb_st == sfp_pkg::WB_ACK);
    assign wb_dat_o = s_reg.rdat;
    assign fifo_data_lines_o = l_reg.dout;
    assign fifo_data_lines_oe_o = l_reg.doe;
    assign status_flag_first_o = l_reg.flags[0];
    assign status_flag_second_o = l_reg.flags[1];
    assign status_flag_third_o = l_reg.flags[2];
    // Internal source clock goes out through an XOR with the invert bit, no flop
    assign interface_clock_o = link_clk_i ^ l_reg.inv; // [RQ10]
    assign interface_clock_oe_o = s_reg.ifcfg[sfp_pkg::IFC_INT_SRC]
                                  & s_reg.ifcfg[sfp_pkg::IFC_PIN_OE]; // [RQ9]
    assign ifc_rate48_o = s_reg.ifcfg[sfp_pkg::IFC_RATE48]; // [RQ9]

    // ========================================
    // Assertions

    sequence s_cfg_write;
        acc && wb_we_i && wb_ack_o && wb_adr_i == sfp_pkg::ADR_IFCFG && wb_sel_i[0];
    endsequence

    sequence s_rd_taken;
        rd_on && port_ok && l_reg.tx_have;
    endsequence

    AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");

    AST_INTERFACE_CLOCK_DRIVE: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i) // [RQ9]
        s_cfg_write |=> interface_clock_oe_o == ($past(wb_dat_i[7]) && $past(wb_dat_i[6])))
        else $error("clock pin enable does not follow config");

    AST_RD_DRIVE: assert property (@(posedge link_clk_i) disable iff (lrst || !lce) // [RQ3]
        s_rd_taken |=> fifo_data_lines_oe_o[0] && !l_reg.tx_have)
        else $error("read strobe did not drive low byte");

    AST_RD_IDLE: assert property (@(posedge link_clk_i) disable iff (lrst || !lce) // [RQ3]
        !rd_on |=> fifo_data_lines_oe_o == 2'h0) else $error("bus driven without read");

    AST_WR_TAKE: assert property (@(posedge link_clk_i) disable iff (lrst || !lce) // [RQ4]
        wr_on && port_ok && !busy |=> $changed(l_reg.rx_tgl) && busy)
        else $error("write strobe did not take a word");

    AST_CMD_LOW: assert property (@(posedge link_clk_i) disable iff (lrst || !lce) // [RQ2]
        cmd && rd_on |=> !fifo_data_lines_oe_o[1]) else $error("command drove high byte");

    AST_NARROW: assert property (@(posedge link_clk_i) disable iff (lrst || !lce) // [RQ12]
        !x.ifcfg[sfp_pkg::IFC_WIDE] |=> !fifo_data_lines_oe_o[1])
        else $error("high byte driven in narrow mode");

    AST_FLAG_PF: assert property (@(posedge link_clk_i) disable iff (lrst || !lce) // [RQ5]
        x.flagcfg[1:0] == sfp_pkg::FSRC_PF |=> status_flag_first_o == $past(pf_sel))
        else $error("first flag does not show level flag");

    AST_FLAG_FULL: assert property (@(posedge link_clk_i) disable iff (lrst || !lce) // [RQ6]
        x.flagcfg[3:2] == sfp_pkg::FSRC_FULL |=> status_flag_second_o == $past(full_sel))
        else $error("second flag does not show full");

    AST_FLAG_EMPTY: assert property (@(posedge link_clk_i) disable iff (lrst || !lce) // [RQ7]
        x.flagcfg[5:4] == sfp_pkg::FSRC_EMPTY |=> status_flag_third_o == $past(empty_sel))
        else $error("third flag does not show empty");

endmodule : sfp_port

// ===== testbench/sfp_master_model.sv
// Purpose: External master model that drives the link pins of the host port
// Assumes: Polarity inputs match what the device's strobe configuration holds
// Notes: Idle data flips every link cycle, so a stale word never reads as valid

`timescale 1ns/1ps

module sfp_master_model (
    // Link clock and strobe polarity (1 = active high)
    input wire logic link_clk_i,
    input wire logic pol_rd_i,
    input wire logic pol_wr_i,
    // Wire level of the data lines and the device's byte enables
    input wire logic [15:0] lines_i,
    input wire logic [1:0] oe_i,
    // Pins driven by the master
    output logic [2:0] sel_o,
    output logic rd_o,
    output logic wr_o,
    output logic [15:0] dat_o
);
    logic rd_act = 1'b0;
    logic wr_act = 1'b0;
    logic drv = 1'b0;
    logic flip = 1'b0;
    logic [15:0] wdat = 16'h0000;
    logic [15:0] last = 16'h0000;

    // ========================================
    // Pins: strobes at the programmed level, write data while writing, flipping idle data otherwise
    initial sel_o = 3'h0;
    assign rd_o = rd_act ? pol_rd_i : ~pol_rd_i;
    assign wr_o = wr_act ? pol_wr_i : ~pol_wr_i;
    assign dat_o = drv ? wdat : (flip ? last : ~last);
    always @(posedge link_clk_i) flip <= ~flip;

    // Select a FIFO and let n link edges pass
    task automatic idle(input logic [2:0] s, input int n);
        @(posedge link_clk_i);
        sel_o <= s;
        repeat (n) @(posedge link_clk_i);
    endtask : idle

    // One write word, taken at the edge that ends the strobe cycle
    task automatic put(input logic [2:0] s, input logic [15:0] d);
        @(posedge link_clk_i);
        sel_o <= s;
        wdat <= d;
        drv <= 1'b1;
        wr_act <= 1'b1;
        @(posedge link_clk_i);
        drv <= 1'b0;
        wr_act <= 1'b0;
        last <= d;
    endtask : put

    // One read word; the device's answer is sampled one edge after the strobe
    task automatic get(input logic [2:0] s, output logic [17:0] d);
        @(posedge link_clk_i);
        sel_o <= s;
        rd_act <= 1'b1;
        @(posedge link_clk_i);
        rd_act <= 1'b0;
        @(posedge link_clk_i);
        d = {oe_i, oe_i[1] ? lines_i[15:8] : 8'h00, lines_i[7:0]};
    endtask : get
endmodule : sfp_master_model

// ===== testbench/slave_fifo_host_port_pins_bench.sv
// Purpose: Self-checking bench for the slave FIFO host port
// Assumes: Config changes only while the link is idle
// Notes: Expected values come from a small queue model in the bench

`timescale 1ns/1ps

module slave_fifo_host_port_pins_bench;
    logic clk_i = 1'b0;
    logic link_clk = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_wdat = 32'h0;
    logic [31:0] wb_rdat;
    logic wb_ack;
    logic pol_rd = 1'b0;
    logic pol_wr = 1'b0;
    logic [2:0] m_sel;
    logic m_rd;
    logic m_wr;
    logic [15:0] m_dat;
    logic [15:0] d_out;
    logic [1:0] d_oe;
    logic [15:0] lines;
    logic f1, f2, f3, ck_o, ck_oe, rate;
    int n_errors = 0;
    int samples_checked = 0;
    logic [31:0] r;
    logic [17:0] g;
    logic [31:0] rx_q[$];

    // ========================================
    // Clocks: link edges sit on odd ns, system edges on multiples of 50
    always #50 clk_i = ~clk_i;
    initial begin
        #7;
        forever #16 link_clk = ~link_clk;
    end
    // Byte lanes resolve between device and master by the device's enables
    assign lines = {d_oe[1] ? d_out[15:8] : m_dat[15:8], d_oe[0] ? d_out[7:0] : m_dat[7:0]};

    sfp_port dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf),
        .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .link_clk_i(link_clk),
        .fifo_select_lines_i(m_sel), .fifo_read_strobe_i(m_rd), .fifo_write_strobe_i(m_wr),
        .fifo_data_lines_i(lines), .fifo_data_lines_o(d_out), .fifo_data_lines_oe_o(d_oe),
        .status_flag_first_o(f1), .status_flag_second_o(f2), .status_flag_third_o(f3),
        .interface_clock_o(ck_o), .interface_clock_oe_o(ck_oe), .ifc_rate48_o(rate));
    sfp_master_model mm (.link_clk_i(link_clk), .pol_rd_i(pol_rd), .pol_wr_i(pol_wr),
        .lines_i(lines), .oe_i(d_oe), .sel_o(m_sel), .rd_o(m_rd), .wr_o(m_wr), .dat_o(m_dat));

    // ========================================
    // Verdict and counts, reached from the main run and from every timeout
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask : chk

    // Classic Wishbone single cycle; waits for ack under a bound
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_wdat <= d;
        for (k = 0; k < 20; k++) begin
            @(posedge clk_i);
            if (wb_ack === 1'b1) break;
        end
        if (k == 20) begin
            n_errors++;
            wrap_up();
        end
        r = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask : wb

    // Flag source pick: level flag, full, empty or off
    function automatic logic pick(input logic [1:0] src, input int s, input logic [11:0] fs);
        return (src == 2'h3) ? 1'b0 : fs[4 * src + s];
    endfunction : pick

    // ========================================
    // Main sequence
    initial begin
        logic [7:0] adrs[5];
        logic [31:0] rsts[5];
        logic [11:0] fs;
        logic [5:0] cfgs[2];
        logic [7:0] ccfg[3];
        logic [15:0] d;
        logic nar;
        int k;
        adrs = '{sfp_pkg::ADR_IFCFG, sfp_pkg::ADR_POLARITY_CONFIG_REG, sfp_pkg::ADR_FLAGCFG,
            sfp_pkg::ADR_FSTAT, 8'h1c};
        rsts = '{32'h01, 32'h00, 32'h24, 32'hf00, 32'h0};
        cfgs = '{6'h24, 6'h1b};
        ccfg = '{8'hd0, 8'he0, 8'h80};
        k = $urandom(32'h27c8a6fb);
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values and one unmapped word
        for (int i = 0; i < 5; i++) begin
            wb(1'b0, adrs[i], 32'h0);
            chk(r, rsts[i]);
        end
        // Flags follow the selected FIFO; a queued word leaves empty to the FSTAT bit
        d = 16'($urandom);
        wb(1'b1, sfp_pkg::ADR_TXDATA, {16'h0, d});
        fs = 12'($urandom);
        wb(1'b1, sfp_pkg::ADR_FSTAT, {20'h0, fs});
        foreach (cfgs[c]) begin
            wb(1'b1, sfp_pkg::ADR_FLAGCFG, {26'h0, cfgs[c]});
            for (int s = 0; s < 4; s++) begin
                mm.idle(3'(s), 6);
                chk({f1, f2, f3}, {pick(cfgs[c][1:0], s, fs), pick(cfgs[c][3:2], s, fs),
                    pick(cfgs[c][5:4], s, fs)});
            end
        end
        // Drain the queued word, then empty shows that no word is held
        mm.get(3'h0, g);
        chk(32'(g), {14'h0, 2'b11, d});
        mm.idle(3'h0, 2);
        chk({f2, f3}, {1'b1, fs[4]});
        // Traffic both ways over polarities, widths, the four FIFO selects and the command select
        for (int p = 0; p < 2; p++) begin
            for (int w = 0; w < 2; w++) begin
                // Park on a spare select, or a polarity swap reads as a strobe
                mm.idle(3'h5, 1);
                wb(1'b1, sfp_pkg::ADR_POLARITY_CONFIG_REG, p ? 32'h0c : 32'h00);
                wb(1'b1, sfp_pkg::ADR_IFCFG, 32'(w));
                pol_rd <= p[0];
                pol_wr <= p[0];
                for (int s = 0; s < 5; s++) begin
                    nar = (w == 0) || (s == 4);
                    mm.idle(3'(s), 4);
                    d = 16'($urandom);
                    rx_q.push_back(nar ? {24'h0, d[7:0]} : {16'h0, d});
                    mm.put(3'(s), d);
                    for (k = 0; k < 40; k++) begin
                        wb(1'b0, sfp_pkg::ADR_STATUS, 32'h0);
                        if (r[0] === 1'b1) break;
                    end
                    if (k == 40) begin
                        n_errors++;
                        wrap_up();
                    end
                    chk(r, {26'h0, 3'(s), s == 4, 2'b01});
                    wb(1'b0, sfp_pkg::ADR_RXDATA, 32'h0);
                    chk(r, rx_q.pop_front());
                    d = 16'($urandom);
                    wb(1'b1, sfp_pkg::ADR_TXDATA, {16'h0, d});
                    mm.idle(3'(s), 8);
                    mm.get(3'(s), g);
                    chk(32'(g), nar ? {14'h0, 2'b01, 8'h00, d[7:0]} :
                        {14'h0, 2'b11, d});
                    mm.get(3'(s), g);
                    chk(32'(g[17:16]), 32'h0);
                end
            end
        end
        // Clock pin source, rate and inversion
        foreach (ccfg[c]) begin
            wb(1'b1, sfp_pkg::ADR_IFCFG, {24'h0, ccfg[c]});
            repeat (2) @(posedge clk_i);
            for (int i = 0; i < 4; i++) begin
                @(posedge clk_i);
                chk({ck_oe, rate, ck_o}, {ccfg[c][7] & ccfg[c][6], ccfg[c][5],
                    link_clk ^ ccfg[c][4]});
            end
        end
        wrap_up();
    end

    // Overall guard against a hang
    initial begin
        repeat (100000) @(posedge clk_i);
        n_errors++;
        wrap_up();
    end
endmodule : slave_fifo_host_port_pins_bench
